//--- inc/lsu_regs.svh
// Purpose: named constants for the accumulator load/store unit
// Assumes: one clock, synchronous active-low reset
// Notes:   widths, counts and encodings used by the datapath
//
// What this block does
// RULE1 - address load converts octal operand to binary
// RULE2 - load of zero sets load zero flag
// RULE3 - back-to-back loads push earlier accumulator value
// RULE4 - indexed load adds stack offset, clears upper
// RULE5 - table load picks constant by stack offset
// RULE6 - real load moves 32 bits, memory or immediate
// RULE7 - single store writes accumulator low word
// RULE8 - double store writes two consecutive words
// RULE9 - bit-field store writes 1..32 low bits
// RULE10 - indexed store writes stack word, clears upper
// RULE11 - eight level stack drops oldest on push
// RULE12 - accumulator cleared at every scan end
// RULE13 - store cancels the pending push
`ifndef LSU_REGS_SVH
`define LSU_REGS_SVH

`define ACC_W          32
`define WORD_W         16
`define HALF_LO        15:0
`define HALF_HI        31:16
`define STACK_DEPTH    8
`define CNT_W          6
`define BITS_MAX       6'h20
`define BITS_MIN       6'h01
`define OCT_DIGITS     6
`define OCT_BIN_W      18
`define ACC_ZERO       32'h0000_0000
`define WORD_ZERO      16'h0000
`define ADDR_ONE       16'h0001
`define CNT_ZERO       6'h00
`define CNT_ONE        6'h01

`endif

//--- inc/lsu_pkg.sv
// Purpose: types shared by the load/store unit modules
// Assumes: lsu_regs.svh holds the numeric constants
// Notes:   operation codes and controller states
`default_nettype none
package lsu_pkg;

    typedef enum logic [3:0] {
        OP_OCTAL_ADDRESS_LOAD,
        OP_INDEXED_WORD_LOAD,
        OP_TABLE_INDEXED_LOAD,
        OP_REAL_VALUE_LOAD,
        OP_SINGLE_WORD_STORE,
        OP_DOUBLE_WORD_STORE,
        OP_BIT_FIELD_STORE,
        OP_INDEXED_WORD_STORE
    } op_code_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_EXEC,
        S_RD_A,
        S_RD_B,
        S_RD_C,
        S_WR_A,
        S_WR_B,
        S_BITS
    } lsu_state_t;

endpackage
`default_nettype wire

//--- inc/acc_stack_if.sv
// Purpose: link between the controller and the accumulator stack
// Assumes: one clock domain
// Notes:   push is a one-cycle strobe with its data
`default_nettype none
`include "lsu_regs.svh"
interface acc_stack_if;
    logic                push;
    logic [`ACC_W-1:0]   push_data;
    logic [`ACC_W-1:0]   level1;

    modport ctrl  (output push, output push_data, input  level1);
    modport stack (input  push, input  push_data, output level1);
endinterface
`default_nettype wire

//--- rtl/acc_stack.sv
// Purpose: eight level accumulator stack
// Assumes: push strobe from the controller
// Notes:   the oldest level falls off on push
`default_nettype none
`include "lsu_regs.svh"
module acc_stack (
    input  wire logic    sys_clk,
    input  wire logic    rstn,
    acc_stack_if.stack   stk
);
    logic [`ACC_W-1:0] level_q [`STACK_DEPTH];

    // ----------------------------------------
    // shift levels down on push
    // ----------------------------------------
    genvar i;
    for (i = 0; i < `STACK_DEPTH; i++) begin : g_level
        if (i == 0) begin : g_top
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    level_q[i] <= `ACC_ZERO;
                end else if (stk.push) begin
                    level_q[i] <= stk.push_data;
                end
            end
        end else begin : g_rest
            always_ff @(posedge sys_clk) begin
                if (!rstn) begin
                    level_q[i] <= `ACC_ZERO;
                end else if (stk.push) begin
                    level_q[i] <= level_q[i-1]; // RULE11
                end
            end
        end
    end

    assign stk.level1 = level_q[0];
endmodule
`default_nettype wire

//--- rtl/accumulator_load_store_unit.sv
// Purpose: load/store datapath around the accumulator and its stack
// Assumes: word memory answers a read one cycle after mem_rd
// Notes:   one operation at a time, taken while op_ready is high
`default_nettype none
`include "lsu_regs.svh"
module accumulator_load_store_unit
    import lsu_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rstn,
    input  wire logic                 op_valid,
    input  wire op_code_t             op_code,
    input  wire logic [`ACC_W-1:0]    op_operand,
    input  wire logic [`CNT_W-1:0]    op_count,
    input  wire logic                 op_imm,
    input  wire logic                 scan_end,
    input  wire logic [`WORD_W-1:0]   mem_rdata,
    output logic                      op_ready,
    output logic                      op_done,
    output logic [`ACC_W-1:0]         acc,
    output logic                      load_zero_flag,
    output logic                      mem_rd,
    output logic                      mem_wr,
    output logic                      mem_const,
    output logic [`WORD_W-1:0]        mem_addr,
    output logic [`WORD_W-1:0]        mem_wdata,
    output logic                      bit_we,
    output logic [`WORD_W-1:0]        bit_addr,
    output logic                      bit_wdata
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    lsu_state_t              state_q;
    lsu_state_t              state_d;
    op_code_t                op_q;
    logic [`ACC_W-1:0]       opnd_q;
    logic                    imm_q;
    logic [`CNT_W-1:0]       last_q;
    logic [`CNT_W-1:0]       bit_idx_q;
    logic [`CNT_W-1:0]       bit_idx_d;
    logic [`CNT_W-1:0]       cnt_eff;
    logic [`WORD_W-1:0]      lo_q;
    logic [`ACC_W-1:0]       acc_q;
    logic                    zero_q;
    logic                    pending_q;
    logic                    ready_q;
    logic                    done_q;
    logic                    mem_rd_q;
    logic                    mem_wr_q;
    logic                    mem_const_q;
    logic [`WORD_W-1:0]      mem_addr_q;
    logic [`WORD_W-1:0]      mem_wdata_q;
    logic                    bit_we_q;
    logic [`WORD_W-1:0]      bit_addr_q;
    logic                    bit_wdata_q;
    logic                    accept;
    logic                    accept_load;
    logic                    accept_store;
    logic                    load_fin;
    logic [`ACC_W-1:0]       load_val;
    logic [`OCT_BIN_W-1:0]   oct_bin;
    logic [`WORD_W-1:0]      addr_eff;
    logic [`WORD_W-1:0]      addr_hi;
    logic                    is_double;

    acc_stack_if stk ();

    acc_stack u_stack (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .stk     (stk)
    );

    // ----------------------------------------
    // operation acceptance
    // ----------------------------------------
    assign accept = op_valid && (state_q == S_IDLE);

    always_comb begin
        case (op_code)
            OP_OCTAL_ADDRESS_LOAD,
            OP_INDEXED_WORD_LOAD,
            OP_TABLE_INDEXED_LOAD,
            OP_REAL_VALUE_LOAD: begin
                accept_load  = accept;
                accept_store = 1'b0;
            end
            default: begin
                accept_load  = 1'b0;
                accept_store = accept;
            end
        endcase
    end

    // push the old accumulator before the new load lands
    assign stk.push      = accept_load && pending_q; // RULE3
    assign stk.push_data = acc_q;

    always_comb begin
        if (op_count > `BITS_MAX) begin
            cnt_eff = `BITS_MAX;
        end else if (op_count == `CNT_ZERO) begin
            cnt_eff = `BITS_MIN;
        end else begin
            cnt_eff = op_count;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            op_q   <= OP_OCTAL_ADDRESS_LOAD;
            opnd_q <= `ACC_ZERO;
            imm_q  <= 1'b0;
            last_q <= `CNT_ZERO;
        end else if (accept) begin
            op_q   <= op_code;
            opnd_q <= op_operand;
            imm_q  <= op_imm;
            last_q <= cnt_eff - `CNT_ONE; // RULE9
        end
    end

    // ----------------------------------------
    // pending push tracking
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            pending_q <= 1'b0;
        end else if (scan_end) begin
            pending_q <= 1'b0;
        end else if (accept_load) begin
            pending_q <= 1'b1; // RULE3
        end else if (accept_store) begin
            pending_q <= 1'b0; // RULE13
        end
    end

    // ----------------------------------------
    // address arithmetic
    // ----------------------------------------
    genvar g;
    for (g = 0; g < `OCT_DIGITS; g++) begin : g_oct
        assign oct_bin[3*g +: 3] = opnd_q[4*g +: 3]; // RULE1
    end

    always_comb begin
        case (op_q)
            OP_INDEXED_WORD_LOAD,
            OP_TABLE_INDEXED_LOAD: addr_eff = opnd_q[`HALF_LO] + stk.level1[`HALF_LO]; // RULE4 RULE5
            OP_INDEXED_WORD_STORE: addr_eff = opnd_q[`HALF_LO] + acc_q[`HALF_LO]; // RULE10
            default:               addr_eff = opnd_q[`HALF_LO];
        endcase
    end

    assign addr_hi   = addr_eff + `ADDR_ONE;
    assign is_double = (op_q == OP_REAL_VALUE_LOAD) || (op_q == OP_DOUBLE_WORD_STORE);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (op_valid) begin
                    state_d = S_EXEC;
                end
            end
            S_EXEC: begin
                case (op_q)
                    OP_OCTAL_ADDRESS_LOAD: state_d = S_IDLE;
                    OP_REAL_VALUE_LOAD:    state_d = imm_q ? S_IDLE : S_RD_A;
                    OP_INDEXED_WORD_LOAD,
                    OP_TABLE_INDEXED_LOAD: state_d = S_RD_A;
                    OP_BIT_FIELD_STORE:    state_d = S_BITS;
                    default:               state_d = S_WR_A;
                endcase
            end
            S_RD_A: state_d = S_RD_B;
            S_RD_B: state_d = is_double ? S_RD_C : S_IDLE;
            S_RD_C: state_d = S_IDLE;
            S_WR_A: state_d = is_double ? S_WR_B : S_IDLE;
            S_WR_B: state_d = S_IDLE;
            S_BITS: begin
                if (bit_idx_q == last_q) begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            ready_q <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            ready_q <= (state_d == S_IDLE);
            done_q  <= (state_q != S_IDLE) && (state_d == S_IDLE);
        end
    end

    // ----------------------------------------
    // load result
    // ----------------------------------------
    always_comb begin
        load_fin = 1'b0;
        load_val = `ACC_ZERO;
        case (state_q)
            S_EXEC: begin
                if (op_q == OP_OCTAL_ADDRESS_LOAD) begin
                    load_fin = 1'b1;
                    load_val = {`WORD_ZERO, oct_bin[`HALF_LO]}; // RULE1
                end else if (op_q == OP_REAL_VALUE_LOAD && imm_q) begin
                    load_fin = 1'b1;
                    load_val = opnd_q; // RULE6
                end
            end
            S_RD_B: begin
                if (!is_double) begin
                    load_fin = 1'b1;
                    load_val = {`WORD_ZERO, mem_rdata}; // RULE4 RULE5
                end
            end
            S_RD_C: begin
                load_fin = 1'b1;
                load_val = {mem_rdata, lo_q}; // RULE6
            end
            default: begin
                load_fin = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lo_q <= `WORD_ZERO;
        end else if (state_q == S_RD_B) begin
            lo_q <= mem_rdata;
        end
    end

    // ----------------------------------------
    // accumulator and zero flag
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            acc_q <= `ACC_ZERO;
        end else if (scan_end) begin
            acc_q <= `ACC_ZERO; // RULE12
        end else if (load_fin) begin
            acc_q <= load_val;
        end else if (state_q == S_WR_A && op_q == OP_INDEXED_WORD_STORE) begin
            acc_q[`HALF_HI] <= `WORD_ZERO; // RULE10
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            zero_q <= 1'b0;
        end else if (load_fin) begin
            zero_q <= (load_val == `ACC_ZERO); // RULE2
        end
    end

    // ----------------------------------------
    // word memory port
    // ----------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            mem_rd_q    <= 1'b0;
            mem_wr_q    <= 1'b0;
            mem_const_q <= 1'b0;
            mem_addr_q  <= `WORD_ZERO;
            mem_wdata_q <= `WORD_ZERO;
        end else begin
            mem_rd_q    <= (state_d == S_RD_A) || (state_d == S_RD_B && is_double);
            mem_wr_q    <= (state_d == S_WR_A) || (state_d == S_WR_B); // RULE7 RULE8
            mem_const_q <= (op_q == OP_TABLE_INDEXED_LOAD) && (state_d == S_RD_A); // RULE5
            if (state_d == S_RD_B || state_d == S_WR_B) begin
                mem_addr_q <= addr_hi; // RULE8
            end else begin
                mem_addr_q <= addr_eff;
            end
            if (state_d == S_WR_B) begin
                mem_wdata_q <= acc_q[`HALF_HI]; // RULE8
            end else if (op_q == OP_INDEXED_WORD_STORE) begin
                mem_wdata_q <= stk.level1[`HALF_LO]; // RULE10
            end else begin
                mem_wdata_q <= acc_q[`HALF_LO]; // RULE7
            end
        end
    end

    // ----------------------------------------
    // discrete bit port
    // ----------------------------------------
    assign bit_idx_d = (state_q == S_BITS) ? bit_idx_q + `CNT_ONE : `CNT_ZERO;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            bit_idx_q   <= `CNT_ZERO;
            bit_we_q    <= 1'b0;
            bit_addr_q  <= `WORD_ZERO;
            bit_wdata_q <= 1'b0;
        end else begin
            bit_we_q <= (state_d == S_BITS); // RULE9
            if (state_d == S_BITS) begin
                bit_idx_q   <= bit_idx_d;
                bit_addr_q  <= opnd_q[`HALF_LO] + {{(`WORD_W-`CNT_W){1'b0}}, bit_idx_d};
                bit_wdata_q <= acc_q[bit_idx_d[`CNT_W-2:0]]; // RULE9
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign op_ready       = ready_q;
    assign op_done        = done_q;
    assign acc            = acc_q;
    assign load_zero_flag = zero_q;
    assign mem_rd         = mem_rd_q;
    assign mem_wr         = mem_wr_q;
    assign mem_const      = mem_const_q;
    assign mem_addr       = mem_addr_q;
    assign mem_wdata      = mem_wdata_q;
    assign bit_we         = bit_we_q;
    assign bit_addr       = bit_addr_q;
    assign bit_wdata      = bit_wdata_q;

endmodule
`default_nettype wire

//--- dv/lsu_chk.sv
// Purpose: port-level checks for the load/store unit
// Assumes: one clock, synchronous active-low reset
// Notes:   helper logic records the last taken operation
`default_nettype none
`include "lsu_regs.svh"
module lsu_chk
    import lsu_pkg::*;
(
    input wire logic               sys_clk,
    input wire logic               rstn,
    input wire logic               op_valid,
    input wire op_code_t           op_code,
    input wire logic [`ACC_W-1:0]  op_operand,
    input wire logic [`CNT_W-1:0]  op_count,
    input wire logic               op_ready,
    input wire logic               op_done,
    input wire logic               scan_end,
    input wire logic [`ACC_W-1:0]  acc,
    input wire logic               load_zero_flag,
    input wire logic               mem_wr,
    input wire logic [`WORD_W-1:0] mem_addr,
    input wire logic [`WORD_W-1:0] mem_wdata,
    input wire logic               bit_we
);
    // ----------------
    // helper logic
    // ----------------
    op_code_t          last_q;
    logic [`CNT_W-1:0] want_q;
    logic [`CNT_W-1:0] bits_q;
    wire               take = op_valid && op_ready;
    wire               is_ld = last_q inside {OP_OCTAL_ADDRESS_LOAD, OP_INDEXED_WORD_LOAD,
                                              OP_TABLE_INDEXED_LOAD, OP_REAL_VALUE_LOAD};

    function automatic logic [17:0] oct(input logic [31:0] v);
        oct = 18'h0;
        for (int i = 0; i < 6; i++)
            oct[3*i +: 3] = v[4*i +: 3];
    endfunction

    always_ff @(posedge sys_clk) begin
        if (take) begin
            last_q <= op_code;
            want_q <= (op_count == 6'h00) ? 6'h01 : (op_count > 6'h20) ? 6'h20 : op_count;
            bits_q <= 6'h00;
        end else if (bit_we) begin
            bits_q <= bits_q + 6'h01;
        end
    end

    // ----------------
    // assertions
    // ----------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    a_done_one_cycle: assert property (op_done |=> !op_done)
        else $error("done pulse longer than one cycle");
    a_octal_value: assert property (take && op_code == OP_OCTAL_ADDRESS_LOAD ##1 !scan_end
        |=> op_done && acc == {14'h0, oct($past(op_operand, 2))}) else $error("octal load value wrong");
    a_zero_flag: assert property (op_done && is_ld && !$past(scan_end)
        |-> load_zero_flag == (acc == 32'h0)) else $error("load zero flag wrong");
    a_index_upper: assert property (op_done && !$past(scan_end) && last_q inside
        {OP_INDEXED_WORD_LOAD, OP_TABLE_INDEXED_LOAD} |-> acc[31:16] == 16'h0) else $error("upper half not zero");
    a_single_store: assert property (take && op_code == OP_SINGLE_WORD_STORE |-> ##2 mem_wr
        && mem_addr == $past(op_operand[15:0], 2) && mem_wdata == $past(acc[15:0], 2)) else $error("store wrong");
    a_double_store: assert property (take && op_code == OP_DOUBLE_WORD_STORE |-> ##3 mem_wr
        && mem_addr == $past(op_operand[15:0], 3) + 16'h1 && mem_wdata == $past(acc[31:16], 3))
        else $error("double store high word wrong");
    a_bit_count: assert property (op_done && last_q == OP_BIT_FIELD_STORE |-> bits_q == want_q)
        else $error("bit store count wrong");
    a_index_store: assert property (take && op_code == OP_INDEXED_WORD_STORE |-> ##2 mem_wr
        && mem_addr == $past(op_operand[15:0], 2) + $past(acc[15:0], 2)) else $error("indexed store address wrong");
    a_scan_clear: assert property (scan_end |=> acc == 32'h0)
        else $error("accumulator not cleared at scan end");
endmodule

bind accumulator_load_store_unit lsu_chk i_lsu_chk (.sys_clk, .rstn, .op_valid, .op_code, .op_operand, .op_count,
    .op_ready, .op_done, .scan_end, .acc, .load_zero_flag, .mem_wr, .mem_addr, .mem_wdata, .bit_we);
`default_nettype wire

//--- dv/lsu_mem_model.sv
// Purpose: word, constant and bit memory beside the load/store unit
// Assumes: read data is due the cycle after mem_rd
// Notes:   undriven read data toggles every cycle
`default_nettype none
module lsu_mem_model (
    input  wire logic        sys_clk,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic        mem_const,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic        bit_we,
    input  wire logic [15:0] bit_addr,
    input  wire logic        bit_wdata,
    output logic      [15:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem  [0:65535];
    logic [15:0] cmem [0:65535];
    logic        bits [0:65535];

    initial mem_rdata = 16'h0000;
    always @(posedge sys_clk) begin
        if (mem_rd)
            mem_rdata <= mem_const ? cmem[mem_addr] : mem[mem_addr];
        else
            mem_rdata <= ~mem_rdata;
        if (mem_wr)
            mem[mem_addr] <= mem_wdata;
        if (bit_we)
            bits[bit_addr] <= bit_wdata;
    end
endmodule
`default_nettype wire

//--- dv/accumulator_load_store_unit_tb_top.sv
// Purpose: self-checking bench for the load/store unit
// Assumes: memory model answers reads one cycle late
// Notes:   scenarios run in order; stack contents carry over
`default_nettype none
`include "lsu_regs.svh"
module accumulator_load_store_unit_tb_top
    import lsu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic               sys_clk = 1'h0;
    logic               rstn = 1'h0;
    logic               op_valid = 1'h0;
    op_code_t           op_code = OP_OCTAL_ADDRESS_LOAD;
    logic [`ACC_W-1:0]  op_operand = 32'h0;
    logic [`CNT_W-1:0]  op_count = 6'h0;
    logic               op_imm = 1'h0;
    logic               scan_end = 1'h0;
    logic [`WORD_W-1:0] mem_rdata, mem_addr, mem_wdata, bit_addr;
    logic [`ACC_W-1:0]  acc;
    logic               op_ready, op_done, load_zero_flag, mem_rd, mem_wr, mem_const, bit_we, bit_wdata;
    int                 fails = 0;
    int                 n_checks = 0;

    accumulator_load_store_unit i_accumulator_load_store_unit (.sys_clk, .rstn, .op_valid, .op_code, .op_operand,
        .op_count, .op_imm, .scan_end, .mem_rdata, .op_ready, .op_done, .acc, .load_zero_flag, .mem_rd, .mem_wr,
        .mem_const, .mem_addr, .mem_wdata, .bit_we, .bit_addr, .bit_wdata);
    lsu_mem_model i_lsu_mem_model (.sys_clk, .mem_rd, .mem_wr, .mem_const, .mem_addr, .mem_wdata, .bit_we,
        .bit_addr, .bit_wdata, .mem_rdata);

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end

    // ----------------
    // shared tasks
    // ----------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wait_hi(input int sel);
        for (int i = 0; i < 60; i++) begin
            if ((sel == 0 ? op_ready : op_done) === 1'h1)
                return;
            @(posedge sys_clk);
            #1;
        end
        fails++;
        complete_run();
    endtask

    task automatic run_op(input op_code_t c, input logic [31:0] v, input logic [5:0] n = 6'h0,
                          input logic im = 1'h0);
        wait_hi(0);
        @(posedge sys_clk);
        op_valid <= 1'h1;
        op_code <= c;
        op_operand <= v;
        op_count <= n;
        op_imm <= im;
        @(posedge sys_clk);
        op_valid <= 1'h0;
        #1;
        wait_hi(1);
    endtask

    // ----------------
    // scenarios
    // ----------------
    task automatic t_loads();
        i_lsu_mem_model.mem[16'h0315] = 16'h2345;
        i_lsu_mem_model.cmem[16'h0201] = 16'h2323;
        run_op(OP_OCTAL_ADDRESS_LOAD, 32'h0004_0400);
        chk(acc, 32'h0000_4100);
        run_op(OP_OCTAL_ADDRESS_LOAD, 32'h0017_7777);
        chk(acc, 32'h0000_ffff);
        chk(load_zero_flag, 32'h0);
        run_op(OP_OCTAL_ADDRESS_LOAD, 32'h0);
        chk(load_zero_flag, 32'h1);
        run_op(OP_REAL_VALUE_LOAD, 32'hdead_beef, 6'h0, 1'h1);
        chk(acc, 32'hdead_beef);
        run_op(OP_OCTAL_ADDRESS_LOAD, 32'h0000_0025);
        run_op(OP_INDEXED_WORD_LOAD, 32'h0000_0300);
        chk(acc, 32'h0000_2345);
        run_op(OP_OCTAL_ADDRESS_LOAD, 32'h0000_0001);
        run_op(OP_TABLE_INDEXED_LOAD, 32'h0000_0200);
        chk(acc, 32'h0000_2323);
        $display("test loads done");
    endtask

    task automatic t_stores();
        logic [7:0] bits_exp = 8'hf8;
        i_lsu_mem_model.mem[16'h0400] = 16'h5678;
        i_lsu_mem_model.mem[16'h0401] = 16'h1234;
        i_lsu_mem_model.bits[16'h0027] = 1'h1;
        run_op(OP_REAL_VALUE_LOAD, 32'h0000_0400);
        chk(acc, 32'h1234_5678);
        run_op(OP_SINGLE_WORD_STORE, 32'h0000_0500);
        chk(i_lsu_mem_model.mem[16'h0500], 32'h5678);
        run_op(OP_DOUBLE_WORD_STORE, 32'h0000_0510);
        chk({i_lsu_mem_model.mem[16'h0511], i_lsu_mem_model.mem[16'h0510]}, 32'h1234_5678);
        run_op(OP_BIT_FIELD_STORE, 32'h0000_0020, 6'h07);
        for (int i = 0; i < 8; i++)
            chk(i_lsu_mem_model.bits[16'h0020 + i], bits_exp[i]);
        $display("test stores done");
    endtask

    task automatic t_index_store();
        run_op(OP_REAL_VALUE_LOAD, 32'h0000_3544, 6'h0, 1'h1);
        run_op(OP_REAL_VALUE_LOAD, 32'habcd_ffff, 6'h0, 1'h1);
        run_op(OP_INDEXED_WORD_STORE, 32'h0000_0600);
        chk(i_lsu_mem_model.mem[16'h05ff], 32'h3544);
        chk(acc, 32'h0000_ffff);
        run_op(OP_REAL_VALUE_LOAD, 32'h0000_2222, 6'h0, 1'h1);
        run_op(OP_SINGLE_WORD_STORE, 32'h0000_0800);
        run_op(OP_OCTAL_ADDRESS_LOAD, 32'h0000_0003);
        run_op(OP_INDEXED_WORD_STORE, 32'h0000_0700);
        chk(i_lsu_mem_model.mem[16'h0703], 32'h3544);
        $display("test indexed store done");
    endtask

    task automatic t_scan();
        run_op(OP_REAL_VALUE_LOAD, 32'h0000_0055, 6'h0, 1'h1);
        @(posedge sys_clk);
        scan_end <= 1'h1;
        @(posedge sys_clk);
        scan_end <= 1'h0;
        #1;
        chk(acc, 32'h0);
        run_op(OP_OCTAL_ADDRESS_LOAD, 32'h0000_0005);
        run_op(OP_INDEXED_WORD_STORE, 32'h0000_0900);
        chk(i_lsu_mem_model.mem[16'h0905], 32'h3544);
        $display("test scan end done");
    endtask

    task automatic t_stack();
        for (int k = 1; k <= 10; k++)
            run_op(OP_REAL_VALUE_LOAD, 32'h0000_0100 + k, 6'h0, 1'h1);
        chk(i_accumulator_load_store_unit.u_stack.level_q[0], 32'h0000_0109);
        chk(i_accumulator_load_store_unit.u_stack.level_q[7], 32'h0000_0102);
        $display("test stack depth done");
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'h1;
        #1;
        t_loads();
        t_stores();
        t_index_store();
        t_scan();
        t_stack();
        complete_run();
    end
endmodule
`default_nettype wire
